/* File: pkg/urxb_defines.svh */
// Register offsets, field positions, reset values for the receive buffer block
`ifndef URXB_DEFINES_SVH
`define URXB_DEFINES_SVH
`define URXB_OFF_STATUS  8'h00
`define URXB_OFF_CTRL_B  8'h04
`define URXB_OFF_CTRL_C  8'h08
`define URXB_OFF_DATA    8'h0c
`define URXB_ST_RXC      7
`define URXB_ST_FE       4
`define URXB_ST_DOR      3
`define URXB_ST_UPE      2
`define URXB_B_RXCIE     7
`define URXB_B_RXEN      4
`define URXB_B_RX9       1
`define URXB_C_PEN       5
`define URXB_C_PODD      4
`define URXB_C_STOP      3
`define URXB_C_CSZ_HI    2
`define URXB_C_CSZ_LO    0
`define URXB_CSZ_9BIT    3'h7
`define URXB_CTRL_B_RST  8'h00
`define URXB_CTRL_C_RST  8'h06
`define URXB_DEPTH       2
`endif

/* File: pkg/urxb_pkg.sv */
// Types shared by the receive buffer block
package urxb_pkg;
    typedef struct packed {
        logic [8:0] data;
        logic       par;
        logic       stop;
    } urxb_frame_s;
    typedef struct packed {
        logic [8:0] data;
        logic       fe;
        logic       dor;
        logic       upe;
    } urxb_entry_s;
    typedef enum logic [2:0] {
        URXB_CSZ5 = 3'h0,
        URXB_CSZ6 = 3'h1,
        URXB_CSZ7 = 3'h2,
        URXB_CSZ8 = 3'h3,
        URXB_CSZ9 = 3'h7
    } urxb_csz_e;
endpackage : urxb_pkg

/* File: hdl/urxb_top.sv */
// Receive buffer, error flags and receive-complete request of a serial port
// How it works
// [RULE_01] 9-bit size stores ninth bit per entry, readable in control B.
// [RULE_02] Reading data location pops buffer; flags then show next entry.
// [RULE_03] Receive complete reads one while buffer holds unread entries.
// [RULE_04] Clearing receiver enable flushes all entries; complete flag drops.
// [RULE_05] Request held while enable, flag and global enable are set.
// [RULE_06] Handler must read data location to clear the request.
// [RULE_07] Error flags stored with their frame; read status before data.
// [RULE_08] Writes cannot change error flags; software writes zeros there.
// [RULE_09] Error flags never raise an interrupt request.
// [RULE_10] Frame error is one when the first stop bit was zero.
// [RULE_11] Only the first stop bit checked; stop count setting ignored.
// [RULE_12] Overrun when buffer full, frame waiting and new start seen.
// [RULE_13] Overrun cleared when a frame moves into the buffer.
// [RULE_14] Parity error reads zero when checking is disabled.
// [RULE_15] Checker compares data parity with received parity bit.
// [RULE_16] Parity result stored with the frame, valid until data read.
// [RULE_17] Disable is immediate, aborts reception, releases receive pin.
// [RULE_18] Software empties buffer by reading data until flag clears.
// [RULE_19] Completed frame in shift register moves into the buffer.
// [RULE_20] Unused upper data bits read as zero for short sizes.
// [RULE_21] Odd select zero means even parity, one means odd.
`timescale 1ns/1ps
`default_nettype none
`include "urxb_defines.svh"
module urxb_top
    import urxb_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire urxb_frame_s FRAME,
    input  wire logic        FRAME_VALID,
    input  wire logic        START_SEEN,
    input  wire logic        GLOBAL_IRQ_EN,
    output logic             RX_COMPLETE_IRQ,
    output logic             RX_PIN_OVERRIDE,
    output logic             RX_ABORT,
    output logic [2:0]       CHAR_SIZE,
    output logic             STOP_BIT_COUNT
);
    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic        acc;
    logic        wr_b;
    logic        wr_c;
    logic        rd_data;
    logic        mapped;
    logic [7:0]  ctrl_b_q;
    logic [7:0]  ctrl_c_q;
    logic        rx_en;
    logic        rxc;
    urxb_entry_s mem_q [`URXB_DEPTH];
    logic        rd_ptr_q;
    logic        wr_ptr_q;
    logic [1:0]  cnt_q;
    urxb_frame_s sr_q;
    logic        sr_full_q;
    logic        dor_pend_q;
    logic        push;
    logic        pop;
    urxb_entry_s head;
    urxb_entry_s new_ent;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    assign acc     = PSEL && PENABLE;
    assign wr_b    = acc && PWRITE && hit(PADDR, `URXB_OFF_CTRL_B);
    assign wr_c    = acc && PWRITE && hit(PADDR, `URXB_OFF_CTRL_C);
    assign rd_data = acc && !PWRITE && hit(PADDR, `URXB_OFF_DATA);
    assign mapped  = hit(PADDR, `URXB_OFF_STATUS) || hit(PADDR, `URXB_OFF_CTRL_B)
                  || hit(PADDR, `URXB_OFF_CTRL_C) || hit(PADDR, `URXB_OFF_DATA);
    // Status writes decode to nothing, so software cannot alter the flags [RULE_08]
    // Zero wait states: every access completes in its first access cycle
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_b_q <= `URXB_CTRL_B_RST;
        end else if (CE && wr_b) begin
            ctrl_b_q <= PWDATA[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_c_q <= `URXB_CTRL_C_RST;
        end else if (CE && wr_c) begin
            ctrl_c_q <= PWDATA[7:0];
        end
    end

    assign rx_en           = ctrl_b_q[`URXB_B_RXEN];
    assign RX_PIN_OVERRIDE = rx_en;  // [RULE_17]
    assign RX_ABORT        = !rx_en; // [RULE_17]
    assign CHAR_SIZE       = ctrl_c_q[`URXB_C_CSZ_HI:`URXB_C_CSZ_LO];
    // Stop count only shapes the front end; frame check never looks at it
    assign STOP_BIT_COUNT  = ctrl_c_q[`URXB_C_STOP]; // [RULE_11]

    // ----------------------------------------
    // Frame check and masking
    // ----------------------------------------
    function automatic logic [8:0] mask_of(input logic [2:0] csz);
        unique case (csz)
            3'h0:    mask_of = 9'h01f;
            3'h1:    mask_of = 9'h03f;
            3'h2:    mask_of = 9'h07f;
            3'h3:    mask_of = 9'h0ff;
            3'h7:    mask_of = 9'h1ff;
            default: mask_of = 9'h0ff;
        endcase
    endfunction : mask_of

    always_comb begin
        new_ent.data = sr_q.data & mask_of(CHAR_SIZE); // [RULE_20] [RULE_01]
        new_ent.fe   = !sr_q.stop;                     // [RULE_10] [RULE_11]
        new_ent.dor  = dor_pend_q;                     // [RULE_07]
        // Even: data plus parity bit hold an even count of ones
        new_ent.upe  = ctrl_c_q[`URXB_C_PEN]           // [RULE_14] [RULE_15]
                    && ((^new_ent.data) ^ sr_q.par ^ ctrl_c_q[`URXB_C_PODD]); // [RULE_21]
    end

    // ----------------------------------------
    // Shift register stage and overrun
    // ----------------------------------------
    // A full buffer holds the frame back until a read frees a slot
    assign push = rx_en && sr_full_q && (cnt_q != 2'h2); // [RULE_19]
    assign pop  = rd_data && (cnt_q != 2'h0);            // [RULE_02]

    always_ff @(posedge CLK) begin
        if (RST) begin
            sr_full_q <= 1'b0;
            sr_q      <= '0;
        end else if (CE) begin
            if (!rx_en) begin
                sr_full_q <= 1'b0; // [RULE_17]
            end else if (FRAME_VALID) begin
                sr_full_q <= 1'b1;
                sr_q      <= FRAME;
            end else if (push || (sr_full_q && START_SEEN && !push)) begin
                // A start on a blocked shift register loses the waiting frame
                sr_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            dor_pend_q <= 1'b0;
        end else if (CE) begin
            if (!rx_en) begin
                dor_pend_q <= 1'b0;
            end else if (sr_full_q && !push && START_SEEN) begin
                dor_pend_q <= 1'b1; // [RULE_12]
            end else if (push) begin
                dor_pend_q <= 1'b0; // [RULE_13]
            end
        end
    end

    // ----------------------------------------
    // Two-entry buffer
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            cnt_q    <= 2'h0;
        end else if (CE) begin
            if (!rx_en) begin
                rd_ptr_q <= 1'b0; // [RULE_04]
                wr_ptr_q <= 1'b0;
                cnt_q    <= 2'h0;
            end else begin
                if (push) begin
                    wr_ptr_q <= !wr_ptr_q;
                end
                if (pop) begin
                    rd_ptr_q <= !rd_ptr_q; // [RULE_02]
                end
                cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else if (CE && push) begin
            mem_q[wr_ptr_q] <= new_ent; // [RULE_07] [RULE_16]
        end
    end

    assign head = (cnt_q != 2'h0) ? mem_q[rd_ptr_q] : '0;
    assign rxc  = (cnt_q != 2'h0); // [RULE_03]

    // Error flags stay out of the request by construction
    assign RX_COMPLETE_IRQ = ctrl_b_q[`URXB_B_RXCIE] && rxc && GLOBAL_IRQ_EN; // [RULE_05] [RULE_09]

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Latched at setup so a popping read returns the entry that it removes
    always_ff @(posedge CLK) begin
        if (RST) begin
            PRDATA <= '0;
        end else if (CE && PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= '0;
            unique case (1'b1)
                hit(PADDR, `URXB_OFF_STATUS): begin
                    PRDATA[`URXB_ST_RXC] <= rxc;
                    PRDATA[`URXB_ST_FE]  <= head.fe;  // [RULE_10]
                    PRDATA[`URXB_ST_DOR] <= head.dor;
                    PRDATA[`URXB_ST_UPE] <= head.upe; // [RULE_16]
                end
                hit(PADDR, `URXB_OFF_CTRL_B): begin
                    PRDATA[7:0]          <= ctrl_b_q;
                    PRDATA[`URXB_B_RX9]  <= head.data[8]; // [RULE_01]
                end
                hit(PADDR, `URXB_OFF_CTRL_C): PRDATA[7:0] <= ctrl_c_q;
                hit(PADDR, `URXB_OFF_DATA):   PRDATA[7:0] <= head.data[7:0];
                default:                      PRDATA <= '0;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Stored-entry checks look one edge after the push that wrote them

    a_rxc_level: assert property (CE && rx_en && pop && !push // [RULE_03]
        && cnt_q == 2'h1 |=> !rxc)
        else $error("complete flag stayed up after last read");
    a_flush_empty: assert property (CE && !rx_en |=> !rxc) // [RULE_04]
        else $error("disable did not flush");
    a_irq_level: assert property (CE && rx_en && RX_COMPLETE_IRQ // [RULE_05]
        && !pop && !wr_b |=> RX_COMPLETE_IRQ || !GLOBAL_IRQ_EN)
        else $error("request dropped while flag was set");
    a_pop_adv: assert property (CE && pop && !push && cnt_q == 2'h2
        |=> cnt_q == 2'h1 && rd_ptr_q != $past(rd_ptr_q)) // [RULE_02]
        else $error("read did not advance buffer");
    a_overrun_set: assert property (CE && rx_en && sr_full_q && !push
        && START_SEEN |=> dor_pend_q) // [RULE_12]
        else $error("overrun not flagged");
    a_overrun_clr: assert property (CE && rx_en && push
        && !(sr_full_q && !push && START_SEEN) |=> !dor_pend_q) // [RULE_13]
        else $error("overrun not cleared on transfer");
    a_par_off: assert property (CE && push && !ctrl_c_q[`URXB_C_PEN] // [RULE_14]
        |=> !mem_q[$past(wr_ptr_q)].upe)
        else $error("parity error while checking off");
    a_fe_stop: assert property (CE && push // [RULE_10]
        |=> mem_q[$past(wr_ptr_q)].fe == !$past(sr_q.stop))
        else $error("frame error does not track stop bit");
    a_move_in: assert property (CE && rx_en && sr_full_q && cnt_q == 2'h0
        && !pop |=> cnt_q == 2'h1) // [RULE_19]
        else $error("frame not moved into buffer");
    a_ro_flags: assert property (CE && rx_en && acc && PWRITE && !push // [RULE_08]
        && hit(PADDR, `URXB_OFF_STATUS) |=> $stable(head))
        else $error("register write altered flags");
    a_mask_short: assert property (CE && push && CHAR_SIZE == 3'h0 // [RULE_20]
        |=> mem_q[$past(wr_ptr_q)].data[8:5] == 4'h0)
        else $error("unused data bits not zero");
    a_ninth_keep: assert property (CE && push && CHAR_SIZE == `URXB_CSZ_9BIT // [RULE_01]
        |=> mem_q[$past(wr_ptr_q)].data[8] == $past(sr_q.data[8]))
        else $error("ninth bit not stored");
    a_dor_store: assert property (CE && push // [RULE_07]
        |=> mem_q[$past(wr_ptr_q)].dor == $past(dor_pend_q))
        else $error("overrun not stored with frame");
    a_flags_hold: assert property (CE && rx_en && !pop && !push // [RULE_16]
        && cnt_q != 2'h0 |=> $stable(head))
        else $error("flags changed before data read");
    a_empty_read: assert property (CE && rx_en && rd_data && cnt_q == 2'h0 // [RULE_02]
        && !push |=> cnt_q == 2'h0)
        else $error("read of empty buffer changed fill");

    c_full: cover property (cnt_q == 2'h2);
    c_overrun: cover property (dor_pend_q && push);
    c_pop_push: cover property (pop && push);
    c_flush: cover property (rxc ##1 !rx_en);
    c_ninth: cover property (push && CHAR_SIZE == `URXB_CSZ_9BIT && sr_q.data[8]);
endmodule : urxb_top
`default_nettype wire

/* File: sim/urxb_far_model.sv */
// Remote transmitter front end model for the receive buffer
`timescale 1ns/1ps
`default_nettype none
module urxb_far_model
    import urxb_pkg::*;
(
    input  wire logic   CLK,
    output urxb_frame_s FRAME,
    output logic        FRAME_VALID,
    output logic        START_SEEN
);
    initial begin
        FRAME       = '0;
        FRAME_VALID = 1'b0;
        START_SEEN  = 1'b0;
    end
    // A start pulse precedes each frame, so a blocked frame is dropped and overrun flagged before the next loads
    task automatic send(input urxb_frame_s f);
        @(posedge CLK);
        START_SEEN <= 1'b1;
        @(posedge CLK);
        START_SEEN <= 1'b0;
        @(posedge CLK);
        FRAME       <= f;
        FRAME_VALID <= 1'b1;
        @(posedge CLK);
        FRAME_VALID <= 1'b0;
        // Stale frame bits are not held once the pulse is over
        FRAME       <= ~f;
        repeat (3) @(posedge CLK);
    endtask : send
endmodule : urxb_far_model
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the receive buffer with a queue model
`timescale 1ns/1ps
`default_nettype none
`include "urxb_defines.svh"
module testbench
    import urxb_pkg::*;
;
    logic        clk, rst, ce, psel, pen, pwr, gie, irq, pin, abrt, stp, ok, sr_full, ovr;
    logic        err, ready;
    logic [7:0]  paddr, cb, cc;
    logic [31:0] pwdata, prdata, seed, r;
    logic [2:0]  csz;
    urxb_frame_s frame;
    logic        fval, start;
    urxb_entry_s q[$];
    urxb_entry_s sr;
    int          bad_count, total_checks;
    urxb_top urxb_top_i (.CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(ready),
        .PSLVERR(err), .FRAME(frame), .FRAME_VALID(fval), .START_SEEN(start),
        .GLOBAL_IRQ_EN(gie), .RX_COMPLETE_IRQ(irq), .RX_PIN_OVERRIDE(pin),
        .RX_ABORT(abrt), .CHAR_SIZE(csz), .STOP_BIT_COUNT(stp));
    urxb_far_model urxb_far_model_i (.CLK(clk), .FRAME(frame), .FRAME_VALID(fval),
        .START_SEEN(start));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    //--------------------------------------------------------------------
    // Tasks
    //--------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic conclude();
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (ready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            conclude();
        end
        r   = prdata;
        ok  = err;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb
    task automatic push(input urxb_entry_s e);
        e.dor = ovr;
        ovr   = 1'b0;
        q.push_back(e);
    endtask : push
    task automatic feed(input urxb_frame_s f);
        urxb_entry_s e;
        int          w;
        w      = (cc[2:0] < 4) ? cc[2:0] + 5 : (cc[2:0] == 7) ? 9 : 8;
        e.data = f.data & ((9'h1 << w) - 9'h1);
        e.fe   = !f.stop;
        e.upe  = cc[5] & (f.par != (^e.data ^ cc[4]));
        if (cb[4]) begin
            if (sr_full) ovr = 1'b1;
            sr_full = 1'b0;
            if (q.size() < 2) push(e);
            else begin
                sr      = e;
                sr_full = 1'b1;
            end
        end
        urxb_far_model_i.send(f);
    endtask : feed
    task automatic check_all();
        urxb_entry_s h;
        h    = (q.size() != 0) ? q[0] : '0;
        seed = lfsr(seed);
        gie <= seed[3];
        apb(1'b0, `URXB_OFF_STATUS, 32'h0);
        chk(r, {24'h0, q.size() != 0, 2'b0, h.fe, h.dor, h.upe, 2'b0});
        apb(1'b0, `URXB_OFF_CTRL_B, 32'h0);
        chk(r, {24'h0, cb[7:2], h.data[8], cb[0]});
        chk(irq, cb[7] & (q.size() != 0) & gie);
        chk({pin, abrt, stp, csz}, {cb[4], !cb[4], cc[3:0]});
    endtask : check_all
    task automatic pop_chk();
        urxb_entry_s h;
        h = (q.size() != 0) ? q[0] : '0;
        apb(1'b0, `URXB_OFF_DATA, 32'h0);
        chk(r, {24'h0, h.data[7:0]});
        if (q.size() != 0) begin
            void'(q.pop_front());
            if (sr_full) push(sr);
            sr_full = 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask : pop_chk
    //--------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------
    initial begin
        rst = 1'b1; ce = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; gie = 1'b0; seed = 32'd70087; cb = 8'h00; cc = 8'h06;
        sr_full = 1'b0; ovr = 1'b0; bad_count = 0; total_checks = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        check_all();
        apb(1'b0, `URXB_OFF_CTRL_C, 32'h0);
        chk(r, 32'h6);
        apb(1'b0, 8'h10, 32'h0);
        chk(ok, 1'b1);
        chk(r, 32'h0);
        for (int i = 0; i < 10; i++) begin
            cc = {2'b0, i[1], i[2], i[0], (i % 5 == 4) ? 3'h7 : 3'(i % 5)};
            cb = {seed[5], 2'b0, 1'b1, 4'h0};
            apb(1'b1, `URXB_OFF_CTRL_C, {24'h0, cc});
            apb(1'b1, `URXB_OFF_CTRL_B, {24'h0, cb});
            for (int k = 0; k < 3 + i[0]; k++) begin
                seed = lfsr(seed);
                feed({seed[8:0], seed[9], seed[10] | seed[11]});
            end
            // Zeros on the error flag positions while entries are held
            apb(1'b1, `URXB_OFF_STATUS, 32'he3);
            while (q.size() != 0) begin
                check_all();
                pop_chk();
            end
            pop_chk();
            check_all();
        end
        feed(11'h5a7);
        feed(11'h0c3);
        // A write while the enable is low must not land
        ce <= 1'b0;
        apb(1'b1, `URXB_OFF_CTRL_B, 32'h80);
        ce <= 1'b1;
        check_all();
        cb = 8'h80;
        apb(1'b1, `URXB_OFF_CTRL_B, {24'h0, cb});
        q.delete();
        sr_full = 1'b0;
        ovr     = 1'b0;
        check_all();
        conclude();
    end
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule : testbench
`default_nettype wire
